// File: logic/rdl_oneshot.sv
`timescale 1ns/1ps
module rdl_oneshot #(
  parameter int unsigned CYCLES = 32'h0BEBC200,
  parameter int          W      = 28
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  // trigger and state
  input  wire logic         i_trig,
  output logic              o_active,
  output logic [W-1:0]      o_count
);
  //////////////////////////////////////////////////////////////////////////////
  // counts down from start; a crossing during the pulse does not restart it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_active <= 1'b0;
      o_count  <= '0;
    end else if (!o_active && i_trig) begin
      o_active <= 1'b1;
      o_count  <= W'(CYCLES - 1);
    end else if (o_active) begin
      if (o_count == '0) begin
        o_active <= 1'b0;
      end else begin
        o_count <= o_count - W'(1);
      end
    end
  end
endmodule // rdl_oneshot

// File: logic/rdl_pkg.sv
package rdl_pkg;
  // register map, byte offsets on the control port
  localparam logic [7:0] CFG_ADDR    = 8'h12;
  localparam logic [7:0] STAT_ADDR   = 8'h13;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] STAT_RESET  = 8'h00;
  // field positions
  localparam int CFG_FW_BIT   = 1;
  localparam int CFG_SPARE_BIT = 2;
  localparam int STAT_OVL_BIT = 2;
  localparam int STAT_DOD_BIT = 1;
  localparam int STAT_OPD_BIT = 0;
  // one-shot timing
  localparam int          CLK_KHZ         = 40000;
  localparam int          ONESHOT_TIME_MS = 5000;
  localparam int unsigned ONESHOT_CYCLES  = ONESHOT_TIME_MS * CLK_KHZ;
  localparam int          ONESHOT_W       = 28;
  // threshold figures, current limit select 0 and 1
  localparam int OVC_LIMIT0_MA = 160;
  localparam int OVC_LIMIT1_MA = 60;
  // ring output source selection
  typedef enum logic [1:0] {
    RDL_SRC_HALF  = 2'b00,
    RDL_SRC_FULL  = 2'b01,
    RDL_SRC_ENV   = 2'b10,
    RDL_SRC_SHOT  = 2'b11
  } rdl_src_t;
endpackage

// File: logic/rdl_regs.sv
`timescale 1ns/1ps
module rdl_regs
  import rdl_pkg::*;
#(
  parameter int unsigned ONESHOT_LEN = rdl_pkg::ONESHOT_CYCLES
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // register port from the control port decoder
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic [7:0]      o_reg_rdata,
  output logic            o_reg_rvalid,
  // settings held in neighbouring registers (same clock)
  input  wire logic       i_ring_validation_enable,
  input  wire logic       i_current_limit_select,
  input  wire logic       i_rx_overload_sticky_clr,
  // detector levels from the line side (asynchronous)
  input  wire logic       i_ring_halfwave,
  input  wire logic       i_ring_fullwave,
  input  wire logic       i_ring_envelope,
  input  wire logic       i_ring_thresh_cross,
  input  wire logic       i_rx_overload,
  input  wire logic       i_offhook_mask,
  input  wire logic       i_offhook,
  input  wire logic       i_loop_current,
  input  wire logic       i_line_side_enabled,
  input  wire logic       i_loop_over_limit0,
  input  wire logic       i_loop_over_limit1,
  // outputs
  output logic            o_ring_detect_output,
  output logic            o_rx_overload_sticky,
  output logic            o_rx_overload_irq_flag
);
  import rdl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for the line-side levels
  localparam int NS = 11;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_ring_halfwave, i_ring_fullwave, i_ring_envelope, i_ring_thresh_cross,
                  i_rx_overload, i_offhook_mask, i_offhook, i_loop_current,
                  i_line_side_enabled, i_loop_over_limit0, i_loop_over_limit1};
      sync2_q <= sync1_q;
    end
  end
  logic s_half, s_full, s_env, s_cross, s_ovl, s_mask, s_offhook, s_loop, s_lsen;
  logic s_over0, s_over1;
  assign {s_half, s_full, s_env, s_cross, s_ovl, s_mask, s_offhook, s_loop, s_lsen,
          s_over0, s_over1} = sync2_q;

  //////////////////////////////////////////////////////////////////////////////
  // ring output configuration register
  logic full_wave_select_q;
  logic cfg_spare_q;
  logic cfg_wr;
  assign cfg_wr = i_reg_wr && (i_reg_addr == CFG_ADDR);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      full_wave_select_q <= CFG_RESET[CFG_FW_BIT];
      cfg_spare_q        <= CFG_RESET[CFG_SPARE_BIT];
    end else if (cfg_wr) begin
      full_wave_select_q <= i_reg_wdata[CFG_FW_BIT];
      cfg_spare_q        <= i_reg_wdata[CFG_SPARE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // threshold-crossing one-shot, started on a rising crossing
  logic cross_d1_q;
  logic shot_trig;
  logic shot_active;
  logic [ONESHOT_W-1:0] shot_count;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cross_d1_q <= 1'b0;
    end else begin
      cross_d1_q <= s_cross;
    end
  end
  assign shot_trig = s_cross && !cross_d1_q;
  rdl_oneshot #(
    .CYCLES (ONESHOT_LEN),
    .W      (ONESHOT_W)
  ) u_shot (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_trig    (shot_trig),
    .o_active  (shot_active),
    .o_count   (shot_count)
  );

  //////////////////////////////////////////////////////////////////////////////
  // ring detect output source selection
  rdl_src_t src;
  assign src = rdl_src_t'({i_ring_validation_enable, full_wave_select_q});
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ring_detect_output <= 1'b0;
    end else begin
      unique case (src)
        RDL_SRC_HALF: o_ring_detect_output <= s_half;
        RDL_SRC_FULL: o_ring_detect_output <= s_full;
        RDL_SRC_ENV:  o_ring_detect_output <= s_env;
        RDL_SRC_SHOT: o_ring_detect_output <= shot_active;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // live line fault flags
  logic ovl_cond;
  logic rx_overload_live_flag_q;
  logic supply_dropout_flag_q;
  logic overcurrent_flag_q;
  assign ovl_cond = s_ovl && !s_mask;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_overload_live_flag_q <= STAT_RESET[STAT_OVL_BIT];
      supply_dropout_flag_q   <= STAT_RESET[STAT_DOD_BIT];
      overcurrent_flag_q      <= STAT_RESET[STAT_OPD_BIT];
    end else begin
      rx_overload_live_flag_q <= ovl_cond;
      supply_dropout_flag_q   <= (s_offhook && !s_loop) || (!s_offhook && s_lsen);
      overcurrent_flag_q      <= i_current_limit_select ? s_over1 : s_over0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky overload and its interrupt flag; a new overload beats the clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rx_overload_sticky   <= 1'b0;
      o_rx_overload_irq_flag <= 1'b0;
    end else if (ovl_cond) begin
      o_rx_overload_sticky   <= 1'b1;
      o_rx_overload_irq_flag <= 1'b1;
    end else if (i_rx_overload_sticky_clr) begin
      o_rx_overload_sticky   <= 1'b0;
      o_rx_overload_irq_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port, one cycle after the read strobe
  logic [7:0] cfg_view;
  logic [7:0] stat_view;
  assign cfg_view  = {5'h00, cfg_spare_q, full_wave_select_q, 1'b0};
  assign stat_view = {5'h00, rx_overload_live_flag_q, supply_dropout_flag_q,
                      overcurrent_flag_q};
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (!i_reg_rd) begin
        o_reg_rdata <= 8'h00;
      end else if (i_reg_addr == CFG_ADDR) begin
        o_reg_rdata <= cfg_view;
      end else if (i_reg_addr == STAT_ADDR) begin
        o_reg_rdata <= stat_view;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence shot_start_s;
    !shot_active && shot_trig;
  endsequence
  sequence shot_run_s;
    shot_active && (shot_count == ONESHOT_W'(ONESHOT_LEN - 1));
  endsequence

  a_ring_half_sel: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (src == RDL_SRC_HALF) |=> o_ring_detect_output == $past(s_half))
    else $error("ring output does not follow half-wave detector");
  a_ring_full_sel: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (src == RDL_SRC_FULL) |=> o_ring_detect_output == $past(s_full))
    else $error("ring output does not follow full-wave detector");
  a_ring_env_sel: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (src == RDL_SRC_ENV) |=> o_ring_detect_output == $past(s_env))
    else $error("ring output does not follow validated envelope");
  a_shot_starts: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    shot_start_s |=> shot_run_s)
    else $error("one-shot did not start with full count");
  a_shot_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (shot_active && shot_count != '0) |=> shot_active && shot_count == $past(shot_count) - 1)
    else $error("one-shot ended or skipped before timeout");
  a_shot_drives: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (src == RDL_SRC_SHOT) |=> o_ring_detect_output == $past(shot_active))
    else $error("ring output does not follow one-shot");
  a_ovl_live_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 rx_overload_live_flag_q == $past(s_ovl && !s_mask))
    else $error("live overload flag wrong or not masked by off-hook counter");
  a_dod_flag_val: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 supply_dropout_flag_q == $past((s_offhook && !s_loop) || (!s_offhook && s_lsen)))
    else $error("dropout flag wrong");
  a_opd_threshold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 overcurrent_flag_q == $past(i_current_limit_select ? s_over1 : s_over0))
    else $error("overcurrent flag uses wrong threshold");
  a_sticky_set_wins: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ovl_cond |=> o_rx_overload_sticky && o_rx_overload_irq_flag)
    else $error("sticky overload lost its set");
  a_sticky_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_rx_overload_sticky_clr && !ovl_cond) |=> !o_rx_overload_sticky && !o_rx_overload_irq_flag)
    else $error("sticky overload not cleared");
  a_cfg_reserved: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_reg_rvalid |-> o_reg_rdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
endmodule // rdl_regs

// File: tb/rdl_host.sv
`timescale 1ns/1ps
module rdl_host (
  // clock
  input  wire logic       i_clk,
  // register port toward the device
  output logic [7:0]      o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  // idle port at time zero
  initial begin
    o_addr  = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end
  // one write strobe; address and data scrambled once released
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
  // read strobe; data and valid taken one edge after the read edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule // rdl_host

// File: tb/ring_detect_line_status_regs_test.sv
`timescale 1ns/1ps
module ring_detect_line_status_regs_test;
  import rdl_pkg::*;
  localparam int unsigned LEN = 20;
  typedef struct packed {logic [7:0] cfg; logic [11:0] in; logic [7:0] st; logic ring;} rdl_row_t;
  logic clk, rst, rv, current_limit_select, clr, hw, fw, env, thr, rx_overload_live_flag, msk, oh, lc, lse, o0, o1;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rvalid, ring, sticky, irq, v;
  int errors, samples_checked, cyc, n;
  // inputs {rv,current_limit_select,half,full,env,ovl,mask,offhook,loop,enabled,over160,over60}
  rdl_row_t rows[15] = '{
    '{8'h00, 12'h200, 8'h00, 1'b1}, '{8'h00, 12'h100, 8'h00, 1'b0},
    '{8'h02, 12'h100, 8'h00, 1'b1}, '{8'h02, 12'h200, 8'h00, 1'b0},
    '{8'h00, 12'h880, 8'h00, 1'b1}, '{8'h00, 12'hB00, 8'h00, 1'b0},
    '{8'h00, 12'h040, 8'h04, 1'b0}, '{8'h00, 12'h000, 8'h00, 1'b0},
    '{8'h00, 12'h060, 8'h00, 1'b0}, '{8'h00, 12'h010, 8'h02, 1'b0},
    '{8'h00, 12'h018, 8'h00, 1'b0}, '{8'h00, 12'h004, 8'h02, 1'b0},
    '{8'h00, 12'h002, 8'h01, 1'b0}, '{8'h00, 12'h001, 8'h00, 1'b0},
    '{8'h00, 12'h401, 8'h01, 1'b0}};
  rdl_host host_u (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
                   .i_rdata(rdata), .i_rvalid(rvalid));
  rdl_regs #(.ONESHOT_LEN(LEN)) dut_u (.i_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_ring_validation_enable(rv), .i_current_limit_select(current_limit_select),
    .i_rx_overload_sticky_clr(clr), .i_ring_halfwave(hw), .i_ring_fullwave(fw),
    .i_ring_envelope(env), .i_ring_thresh_cross(thr), .i_rx_overload(rx_overload_live_flag),
    .i_offhook_mask(msk), .i_offhook(oh), .i_loop_current(lc), .i_line_side_enabled(lse),
    .i_loop_over_limit0(o0), .i_loop_over_limit1(o1), .o_ring_detect_output(ring),
    .o_rx_overload_sticky(sticky), .o_rx_overload_irq_flag(irq));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, cycle ceiling
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      results();
    end
  end
  // compare helpers
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] e);
    host_u.rd_reg(a, d, v);
    chk1("rvalid", 1'b1, v);
    chk8("rdata", e, d);
  endtask
  task automatic wait_cyc(int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, rv, current_limit_select, clr, hw, fw, env, thr, rx_overload_live_flag, msk, oh, lc, lse, o0, o1} = 15'h4000;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    wait_cyc(6);
    rst <= 1'b0;
    wait_cyc(3);
    rd_chk(CFG_ADDR, CFG_RESET);
    rd_chk(STAT_ADDR, STAT_RESET);
    $display("test reset done");
    foreach (rows[i]) begin
      host_u.wr_reg(CFG_ADDR, rows[i].cfg);
      {rv, current_limit_select, hw, fw, env, rx_overload_live_flag, msk, oh, lc, lse, o0, o1} <= rows[i].in;
      wait_cyc(5);
      chk1("ring_detect_output", rows[i].ring, ring);
      rd_chk(STAT_ADDR, rows[i].st);
    end
    $display("test table done");
    host_u.wr_reg(CFG_ADDR, 8'hFF);
    rd_chk(CFG_ADDR, 8'h06);
    host_u.wr_reg(STAT_ADDR, 8'hFF);
    {rv, current_limit_select, hw, fw, env, rx_overload_live_flag, msk, oh, lc, lse, o0, o1} <= 12'h000;
    wait_cyc(4);
    rd_chk(STAT_ADDR, 8'h00);
    rd_chk(8'h20, 8'h00);
    $display("test reserved done");
    chk1("sticky", 1'b1, sticky);
    chk1("irq", 1'b1, irq);
    rx_overload_live_flag <= 1'b1;
    wait_cyc(4);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    // look one edge after the clear, before a lost set could be redone
    wait_cyc(1);
    chk1("sticky", 1'b1, sticky);
    chk1("irq", 1'b1, irq);
    rx_overload_live_flag <= 1'b0;
    wait_cyc(4);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_cyc(2);
    chk1("sticky", 1'b0, sticky);
    chk1("irq", 1'b0, irq);
    $display("test sticky done");
    host_u.wr_reg(CFG_ADDR, 8'h02);
    rv <= 1'b1;
    wait_cyc(4);
    chk1("ring_detect_output", 1'b0, ring);
    thr <= 1'b1;
    n = 0;
    for (int k = 0; k < 60; k++) begin
      @(posedge clk);
      if (k == 5 || k == 12) thr <= 1'b0;
      if (k == 10) thr <= 1'b1; // second crossing inside the pulse is ignored
      if (ring === 1'b1) n++;
    end
    chk8("oneshot_cycles", 8'(LEN), 8'(n));
    $display("test oneshot done");
    // mid-run reset: sticky set and config written beforehand
    rx_overload_live_flag <= 1'b1;
    wait_cyc(4);
    chk1("sticky", 1'b1, sticky);
    {rst, rx_overload_live_flag} <= 2'b10;
    wait_cyc(3);
    rst <= 1'b0;
    @(posedge clk);
    chk1("sticky", 1'b0, sticky);
    chk1("irq", 1'b0, irq);
    rd_chk(CFG_ADDR, CFG_RESET);
    $display("test midrun reset done");
    results();
  end
endmodule // ring_detect_line_status_regs_test
